// *** design/bma_pkg.sv ***
// Shared constants and types for the multi-layer bus matrix arbiter.
package bma_pkg;

  // ----------------------------------------------------------------
  // Matrix dimensions
  // ----------------------------------------------------------------
  localparam int NUM_MASTERS = 16;
  localparam int NUM_SLAVES  = 16;
  localparam int IDX_W       = 4;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int SLOT_W      = 8;
  localparam int PRIO_W      = 4;

  // Slave select field of a master address (one decoder per master).
  localparam int SEL_LSB = 28;

  // Reset value of the rotation pointer, so master 0 is served first.
  localparam logic [3:0] RR_PTR_RST = 4'hF;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DEFM_NONE  = 2'h0,
    DEFM_LAST  = 2'h1,
    DEFM_FIXED = 2'h2
  } bma_defm_t;

  localparam logic ARB_ROUND_ROBIN = 1'h0;
  localparam logic ARB_FIXED_PRIO  = 1'h1;

  // Burst kinds as the masters present them.
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_INCR   = 3'h1;
  localparam logic [2:0] BURST_4_MIN  = 3'h2;
  localparam logic [2:0] BURST_8_MIN  = 3'h4;
  localparam logic [2:0] BURST_16_MIN = 3'h6;

  // Predicted end of an undefined-length burst.
  localparam logic [2:0] UB_INFINITE = 3'h0;
  localparam logic [2:0] UB_ONE      = 3'h1;
  localparam logic [2:0] UB_FOUR     = 3'h2;
  localparam logic [2:0] UB_EIGHT    = 3'h3;
  localparam logic [2:0] UB_SIXTEEN  = 3'h4;

  // Predicted burst lengths in beats; zero length means never end.
  localparam logic [4:0] LEN_NEVER = 5'h00;
  localparam logic [4:0] LEN_1     = 5'h01;
  localparam logic [4:0] LEN_4     = 5'h04;
  localparam logic [4:0] LEN_8     = 5'h08;
  localparam logic [4:0] LEN_16    = 5'h10;

endpackage : bma_pkg

// *** design/bma_arb_if.sv ***
// Link between the matrix hub and one per-slave arbiter.
`timescale 1ns/1ps
`default_nettype none
interface bma_arb_if;
  import bma_pkg::*;
  logic [NUM_MASTERS-1:0]             req;
  logic                               arb_ok;
  bma_defm_t                          def_kind;
  logic [IDX_W-1:0]                   fixed_idx;
  logic                               arb_type;
  logic [NUM_MASTERS-1:0][PRIO_W-1:0] prio;
  logic                               grant_vld;
  logic [IDX_W-1:0]                   grant_idx;

  modport hub (output req, arb_ok, def_kind, fixed_idx, arb_type, prio, input grant_vld, grant_idx);
  modport arb (input req, arb_ok, def_kind, fixed_idx, arb_type, prio, output grant_vld, grant_idx);
endinterface : bma_arb_if
`default_nettype wire

// *** design/bma_slave_arbiter.sv ***
// Arbiter for one slave port: picks the connected master.
`timescale 1ns/1ps
`default_nettype none
module bma_slave_arbiter
  import bma_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic nrst,
  // Hub side.
  bma_arb_if.arb   a
);

  logic             vld_r,  vld_nxt;
  logic [IDX_W-1:0] idx_r,  idx_nxt;
  logic [IDX_W-1:0] ptr_r,  ptr_nxt;
  logic [IDX_W-1:0] rr_win, fp_win, cand;
  logic [PRIO_W-1:0] best;
  logic             rr_hit, fp_hit;

  // ----------------------------------------------------------------
  // Winner selection
  // ----------------------------------------------------------------
  // Round robin scans upward from the last winner; fixed priority keeps the
  // highest level, and the >= lets a higher index win a tie.
  always_comb begin
    rr_win = '0;
    rr_hit = 1'b0;
    fp_win = '0;
    fp_hit = 1'b0;
    best   = '0;
    cand   = '0;
    for (int k = 1; k <= NUM_MASTERS; k++) begin
      cand = IDX_W'(ptr_r + IDX_W'(k));
      if (a.req[cand] && !rr_hit) begin
        rr_win = cand;
        rr_hit = 1'b1;
      end
    end
    for (int i = 0; i < NUM_MASTERS; i++) begin
      if (a.req[i] && (!fp_hit || a.prio[i] >= best)) begin
        fp_win = IDX_W'(i);
        best   = a.prio[i];
        fp_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Grant update
  // ----------------------------------------------------------------
  // Outside an arbitration point the grant is frozen, whatever arrives.
  always_comb begin
    vld_nxt = vld_r;
    idx_nxt = idx_r;
    ptr_nxt = ptr_r;
    if (a.arb_ok) begin
      if (|a.req) begin
        vld_nxt = 1'b1;
        if (a.arb_type == ARB_FIXED_PRIO) begin
          idx_nxt = fp_win;
        end else begin
          idx_nxt = rr_win;
          ptr_nxt = rr_win;
        end
      end else begin
        case (a.def_kind)
          DEFM_NONE: begin
            vld_nxt = 1'b0;
          end
          DEFM_LAST: begin
            vld_nxt = vld_r;
          end
          DEFM_FIXED: begin
            vld_nxt = 1'b1;
            idx_nxt = a.fixed_idx;
          end
          default: begin
            vld_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // Grant registers; a new connection appears one cycle after the request.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vld_r <= 1'b0;
      idx_r <= '0;
      ptr_r <= RR_PTR_RST;
    end else begin
      vld_r <= vld_nxt;
      idx_r <= idx_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  assign a.grant_vld = vld_r;
  assign a.grant_idx = idx_r;

endmodule : bma_slave_arbiter
`default_nettype wire

// *** design/bma_matrix.sv ***
// Multi-layer bus matrix: master decoders, per-slave burst tracking, arbiters.
`timescale 1ns/1ps
`default_nettype none
module bma_matrix
  import bma_pkg::*;
(
  // Clock and reset; sys_clk is the gated matrix interface clock.
  input  wire logic                                         sys_clk,
  input  wire logic                                         nrst,
  // Master side requests.
  input  wire logic [NUM_MASTERS-1:0]                       m_trans,
  input  wire logic [NUM_MASTERS-1:0][ADDR_W-1:0]           m_addr,
  input  wire logic [NUM_MASTERS-1:0][2:0]                  m_burst,
  output logic      [NUM_MASTERS-1:0]                       m_grant,
  output logic      [NUM_MASTERS-1:0]                       m_ready,
  output logic      [NUM_MASTERS-1:0][DATA_W-1:0]           m_rdata,
  // Slave side paths.
  output logic      [NUM_SLAVES-1:0]                        s_trans,
  output logic      [NUM_SLAVES-1:0][ADDR_W-1:0]            s_addr,
  output logic      [NUM_SLAVES-1:0][IDX_W-1:0]             s_master,
  input  wire logic [NUM_SLAVES-1:0]                        s_ready,
  input  wire logic [NUM_SLAVES-1:0][DATA_W-1:0]            s_rdata,
  // Per-master configuration.
  input  wire logic [NUM_MASTERS-1:0][2:0]                  undefined_burst_break_select,
  // Per-slave configuration.
  input  wire bma_defm_t [NUM_SLAVES-1:0]                   default_master_kind,
  input  wire logic [NUM_SLAVES-1:0][IDX_W-1:0]             fixed_master_index,
  input  wire logic [NUM_SLAVES-1:0]                        arbitration_type_select,
  input  wire logic [NUM_SLAVES-1:0][SLOT_W-1:0]            slot_cycle,
  input  wire logic [NUM_SLAVES-1:0][7:0][PRIO_W-1:0]       slave_priority_low,
  input  wire logic [NUM_SLAVES-1:0][7:0][PRIO_W-1:0]       slave_priority_high,
  // Special function words.
  input  wire logic [NUM_SLAVES-1:0]                        sfw_wr_en,
  input  wire logic [DATA_W-1:0]                            sfw_wdata,
  output logic      [NUM_SLAVES-1:0][DATA_W-1:0]            special_function_word,
  // Status.
  output logic      [NUM_SLAVES-1:0]                        s_connected
);

  // ----------------------------------------------------------------
  // Master address decoders
  // ----------------------------------------------------------------
  logic [NUM_MASTERS-1:0][IDX_W-1:0] m_sel;

  // Each master owns a decoder, so all masters resolve targets at once.
  always_comb begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      m_sel[m] = m_addr[m][SEL_LSB +: IDX_W];
    end
  end

  // ----------------------------------------------------------------
  // Per-slave burst tracking and arbiters
  // ----------------------------------------------------------------
  bma_arb_if arb_if [NUM_SLAVES] ();

  logic [NUM_SLAVES-1:0][4:0]        cnt_r,  cnt_nxt;
  logic [NUM_SLAVES-1:0][SLOT_W-1:0] slot_r, slot_nxt;
  logic [NUM_SLAVES-1:0]             g_vld;
  logic [NUM_SLAVES-1:0][IDX_W-1:0]  g_idx;
  logic [NUM_SLAVES-1:0]             cur_acc;

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SLAVES; gs++) begin : g_slave
      logic [NUM_MASTERS-1:0] req;
      logic [2:0]             burst;
      logic [4:0]             plen;
      logic                   beat;
      logic                   burst_end;
      logic                   slot_hit;

      // Requests aimed at this slave by the decoders.
      always_comb begin
        for (int m = 0; m < NUM_MASTERS; m++) begin
          req[m] = m_trans[m] && (m_sel[m] == IDX_W'(gs));
        end
      end

      // Predicted burst length of the connected master.
      always_comb begin
        burst = m_burst[g_idx[gs]];
        plen  = LEN_1;
        if (burst == BURST_INCR) begin
          case (undefined_burst_break_select[g_idx[gs]])
            UB_INFINITE: plen = LEN_NEVER;
            UB_ONE:      plen = LEN_1;
            UB_FOUR:     plen = LEN_4;
            UB_EIGHT:    plen = LEN_8;
            UB_SIXTEEN:  plen = LEN_16;
            default:     plen = LEN_NEVER;
          endcase
        end else if (burst >= BURST_16_MIN) begin
          plen = LEN_16;
        end else if (burst >= BURST_8_MIN) begin
          plen = LEN_8;
        end else if (burst >= BURST_4_MIN) begin
          plen = LEN_4;
        end
      end

      // Arbitration points for this slave.
      always_comb begin
        cur_acc[gs] = g_vld[gs] && req[g_idx[gs]];
        beat        = cur_acc[gs] && s_ready[gs];
        burst_end   = beat && (plen != LEN_NEVER) && (cnt_r[gs] == 5'(plen - 5'h01));
        // A zero slot value disables the limit; otherwise break after the beat.
        slot_hit    = beat && (slot_cycle[gs] != '0) && (slot_r[gs] == '0);
        arb_if[gs].arb_ok = !cur_acc[gs]
                          || (burst == BURST_SINGLE)
                          || burst_end
                          || slot_hit;
      end

      // Beat and slot counters; both restart while the slave is idle, at a burst end and at a slot break.
      always_comb begin
        cnt_nxt[gs]  = cnt_r[gs];
        slot_nxt[gs] = slot_r[gs];
        if (!cur_acc[gs] || burst_end || slot_hit) begin
          slot_nxt[gs] = slot_cycle[gs];
        end else if (slot_r[gs] != '0) begin
          slot_nxt[gs] = SLOT_W'(slot_r[gs] - SLOT_W'(1));
        end
        if (!cur_acc[gs] || burst_end || slot_hit) begin
          cnt_nxt[gs] = '0;
        end else if (beat) begin
          cnt_nxt[gs] = 5'(cnt_r[gs] + 5'h01);
        end
      end

      // Configuration handed to the arbiter.
      always_comb begin
        arb_if[gs].req       = req;
        arb_if[gs].def_kind  = default_master_kind[gs];
        arb_if[gs].fixed_idx = fixed_master_index[gs];
        arb_if[gs].arb_type  = arbitration_type_select[gs];
        for (int m = 0; m < 8; m++) begin
          arb_if[gs].prio[m]     = slave_priority_low[gs][m];
          arb_if[gs].prio[m + 8] = slave_priority_high[gs][m];
        end
      end

      assign g_vld[gs] = arb_if[gs].grant_vld;
      assign g_idx[gs] = arb_if[gs].grant_idx;

      bma_slave_arbiter u_arb (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .a       (arb_if[gs])
      );
    end
  endgenerate

  // Counter registers for all slaves.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r  <= '0;
      slot_r <= '0;
    end else begin
      cnt_r  <= cnt_nxt;
      slot_r <= slot_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Data paths
  // ----------------------------------------------------------------
  // Paths are plain muxes on the registered grant, which keeps the default
  // master at zero added latency at the cost of a longer combinational path.
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      s_trans[s]     = cur_acc[s];
      s_addr[s]      = m_addr[g_idx[s]];
      s_master[s]    = g_idx[s];
      s_connected[s] = g_vld[s];
    end
    for (int m = 0; m < NUM_MASTERS; m++) begin
      m_grant[m] = g_vld[m_sel[m]] && (g_idx[m_sel[m]] == IDX_W'(m));
      m_ready[m] = m_grant[m] && m_trans[m] && s_ready[m_sel[m]];
      m_rdata[m] = s_rdata[m_sel[m]];
    end
  end

  // ----------------------------------------------------------------
  // Special function words
  // ----------------------------------------------------------------
  // Storage only; nothing in the matrix reads these words.
  logic [NUM_SLAVES-1:0][DATA_W-1:0] sfw_r, sfw_nxt;

  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      sfw_nxt[s] = sfw_wr_en[s] ? sfw_wdata : sfw_r[s];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sfw_r <= '0;
    end else begin
      sfw_r <= sfw_nxt;
    end
  end

  assign special_function_word = sfw_r;

endmodule : bma_matrix
`default_nettype wire

// *** sim/bma_matrix_assertions.sv ***
// Concurrent checks on the bus matrix top ports.
`timescale 1ns/1ps
`default_nettype none
module bma_matrix_assertions
  import bma_pkg::*;
(
  // Clock and reset.
  input wire logic                               sys_clk,
  input wire logic                               nrst,
  // Master side.
  input wire logic [NUM_MASTERS-1:0]             m_trans,
  input wire logic [NUM_MASTERS-1:0][ADDR_W-1:0] m_addr,
  input wire logic [NUM_MASTERS-1:0][2:0]        m_burst,
  input wire logic [NUM_MASTERS-1:0]             m_grant,
  input wire logic [NUM_MASTERS-1:0]             m_ready,
  // Slave side.
  input wire logic [NUM_SLAVES-1:0]              s_trans,
  input wire logic [NUM_SLAVES-1:0][IDX_W-1:0]   s_master,
  input wire logic [NUM_SLAVES-1:0]              s_ready,
  input wire logic [NUM_SLAVES-1:0]              s_connected,
  // Configuration and spare words.
  input wire bma_defm_t [NUM_SLAVES-1:0]         default_master_kind,
  input wire logic [NUM_SLAVES-1:0][IDX_W-1:0]   fixed_master_index,
  input wire logic [NUM_SLAVES-1:0]              sfw_wr_en,
  input wire logic [DATA_W-1:0]                  sfw_wdata,
  input wire logic [NUM_SLAVES-1:0][DATA_W-1:0]  special_function_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [NUM_SLAVES-1:0][NUM_MASTERS-1:0] reqv;
  // Requests seen by each slave, decoded from every master's address.
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      for (int m = 0; m < NUM_MASTERS; m++) begin
        reqv[s][m] = m_trans[m] && (m_addr[m][SEL_LSB+:IDX_W] == IDX_W'(s));
      end
    end
  end
  // Per-slave default master, spare word and burst hold behaviour.
  for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
    sequence quiet_s;
      s_connected[s] && (reqv[s] == '0);
    endsequence
    none_drop_a:
      assert property ((default_master_kind[s] == DEFM_NONE) ##0 quiet_s |=> !s_connected[s])
      else $error("idle slave kept a master without default");
    last_keep_a:
      assert property ((default_master_kind[s] == DEFM_LAST) ##0 quiet_s |=> s_connected[s] && $stable(s_master[s]))
      else $error("idle slave lost its last master");
    fixed_conn_a:
      assert property ((default_master_kind[s] == DEFM_FIXED) && (reqv[s] == '0)
        |=> s_connected[s] && (s_master[s] == $past(fixed_master_index[s])))
      else $error("idle slave not on its fixed master");
    sfw_write_a:
      assert property (sfw_wr_en[s] |=> special_function_word[s] == $past(sfw_wdata))
      else $error("spare word write lost");
    burst_hold_a:
      assert property (s_trans[s] && !s_ready[s] && (m_burst[s_master[s]] != BURST_SINGLE)
        |=> s_connected[s] && $stable(s_master[s]))
      else $error("grant moved inside a burst");
  end
  // Per-master routing and latency.
  for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_mst
    logic [IDX_W-1:0] sel;
    assign sel = m_addr[m][SEL_LSB+:IDX_W];
    grant_route_a:
      assert property (m_grant[m] |-> s_connected[sel] && (s_master[sel] == IDX_W'(m)))
      else $error("grant without matching connection");
    ready_path_a:
      assert property (m_ready[m] |-> m_grant[m] && m_trans[m] && s_ready[sel])
      else $error("ready without granted path");
    zero_wait_a:
      assert property (m_trans[m] && s_connected[sel] && (s_master[sel] == IDX_W'(m)) |-> m_grant[m])
      else $error("connected master not granted at once");
    one_cycle_a:
      assert property (m_trans[m] && !s_connected[sel] && $onehot(reqv[sel]) |=> m_grant[m])
      else $error("lone request not granted next cycle");
  end
endmodule : bma_matrix_assertions
bind bma_matrix bma_matrix_assertions u_chk (.sys_clk, .nrst, .m_trans, .m_addr, .m_burst, .m_grant, .m_ready,
  .s_trans, .s_master, .s_ready, .s_connected, .default_master_kind, .fixed_master_index, .sfw_wr_en, .sfw_wdata,
  .special_function_word);
`default_nettype wire

// *** sim/bma_slave_model.sv ***
// Slave-side model: answers every connected beat, with bench-driven wait states.
`timescale 1ns/1ps
`default_nettype none
module bma_slave_model
  import bma_pkg::*;
(
  // Clock and reset.
  input  wire logic                              sys_clk,
  input  wire logic                              nrst,
  // Matrix slave side.
  input  wire logic [NUM_SLAVES-1:0]             s_trans,
  input  wire logic [NUM_SLAVES-1:0][IDX_W-1:0]  s_master,
  output logic      [NUM_SLAVES-1:0]             s_ready,
  output logic      [NUM_SLAVES-1:0][DATA_W-1:0] s_rdata,
  // Wait states asked by the bench.
  input  wire logic [NUM_SLAVES-1:0]             stall
);
  logic [DATA_W-1:0] churn_r;
  // Running pattern, so data outside a beat never looks like a stale word.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) churn_r <= 32'h0000_0000;
    else churn_r <= churn_r + 32'h0001_0003;
  end
  // Data names its owner and slave, so a wrong route shows at the master.
  always_comb begin
    for (int s = 0; s < NUM_SLAVES; s++) begin
      s_ready[s] = s_trans[s] && !stall[s];
      s_rdata[s] = s_ready[s] ? {24'h00_0000, s_master[s], IDX_W'(s)} : ~churn_r;
    end
  end
endmodule : bma_slave_model
`default_nettype wire

// *** sim/test_bma_matrix.sv ***
// Self-checking bench for the bus matrix: grant order, default masters, spare words.
`timescale 1ns/1ps
`default_nettype none
module test_bma_matrix
  import bma_pkg::*;
;
  logic                                   sys_clk;
  logic                                   nrst;
  logic [NUM_MASTERS-1:0]                 m_trans, m_grant, m_ready;
  logic [NUM_MASTERS-1:0][ADDR_W-1:0]     m_addr;
  logic [NUM_MASTERS-1:0][2:0]            m_burst, undefined_burst_break_select;
  logic [NUM_MASTERS-1:0][DATA_W-1:0]     m_rdata;
  logic [NUM_SLAVES-1:0]                  s_trans, s_ready, s_connected, sfw_wr_en, stall, arbitration_type_select;
  logic [NUM_SLAVES-1:0][ADDR_W-1:0]      s_addr;
  logic [NUM_SLAVES-1:0][IDX_W-1:0]       s_master, fixed_master_index;
  logic [NUM_SLAVES-1:0][DATA_W-1:0]      s_rdata, special_function_word;
  logic [NUM_SLAVES-1:0][SLOT_W-1:0]      slot_cycle;
  logic [NUM_SLAVES-1:0][7:0][PRIO_W-1:0] slave_priority_low, slave_priority_high;
  bma_defm_t [NUM_SLAVES-1:0]             default_master_kind;
  logic [DATA_W-1:0]                      sfw_wdata, lfsr_r;
  logic [IDX_W-1:0]                       expq[$];
  int                                     left[NUM_MASTERS];
  int                                     miscompares, check_count;

  bma_matrix DUT (.sys_clk, .nrst, .m_trans, .m_addr, .m_burst, .m_grant, .m_ready, .m_rdata, .s_trans, .s_addr,
    .s_master, .s_ready, .s_rdata, .undefined_burst_break_select, .default_master_kind, .fixed_master_index,
    .arbitration_type_select, .slot_cycle, .slave_priority_low, .slave_priority_high, .sfw_wr_en, .sfw_wdata,
    .special_function_word, .s_connected);
  bma_slave_model u_slv (.sys_clk, .nrst, .s_trans, .s_master, .s_ready, .s_rdata, .stall);

  // Free-running clock at 125 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    return lfsr_r;
  endfunction : rnd

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // Master m starts n beats to slave s; the address tail is random.
  task automatic go(int m, int s, logic [2:0] b, int n);
    m_addr[m] = {4'(s), 28'(rnd())};
    m_burst[m] = b;
    left[m] = n;
    m_trans[m] = 1'b1;
  endtask : go

  task automatic note(int m, int n);
    repeat (n) expq.push_back(4'(m));
  endtask : note

  // Bounded wait until every master is quiet and every expected beat was seen.
  task automatic settle(string name);
    int k;
    k = 0;
    while ((m_trans !== '0 || expq.size() != 0) && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    if (m_trans !== '0 || expq.size() != 0) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, m_trans, 16'h0000);
      test_done();
    end
    repeat (2) @(negedge sys_clk);
    $display("test %s finished", name);
  endtask : settle

  // Each completed beat is matched against the oldest expected owner.
  always @(posedge sys_clk) begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      if (nrst && m_ready[m] === 1'b1) begin
        chk(32'(m), (expq.size() != 0) ? 32'(expq.pop_front()) : 32'hFFFF_FFFF);
        chk(m_rdata[m], {24'h00_0000, 4'(m), m_addr[m][SEL_LSB+:IDX_W]});
        chk(s_addr[m_addr[m][SEL_LSB+:IDX_W]], m_addr[m]);
        left[m]--;
      end
    end
  end

  // A master drops its request on the falling edge after its last beat.
  always @(negedge sys_clk) begin
    for (int m = 0; m < NUM_MASTERS; m++) begin
      if (left[m] == 0 && m_trans[m]) m_trans[m] = 1'b0;
    end
  end

  initial begin
    lfsr_r = 32'h9afd_61f4;
    nrst = 1'b0;
    {m_trans, m_addr, m_burst, sfw_wr_en, sfw_wdata, stall, slot_cycle} = '0;
    {arbitration_type_select, fixed_master_index, slave_priority_low, slave_priority_high} = '0;
    for (int i = 0; i < NUM_MASTERS; i++) undefined_burst_break_select[i] = UB_ONE;
    for (int i = 0; i < NUM_SLAVES; i++) default_master_kind[i] = DEFM_NONE;
    default_master_kind[6] = DEFM_LAST;
    default_master_kind[7] = DEFM_FIXED;
    fixed_master_index[7] = 4'h9;
    arbitration_type_select[2] = ARB_FIXED_PRIO;
    slave_priority_low[2][0] = 4'h3;
    slave_priority_low[2][5] = 4'h7;
    slave_priority_high[2][2] = 4'h7;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int s = 0; s < NUM_SLAVES; s++) chk(special_function_word[s], 32'h0000_0000);
    chk({s_connected[7], s_master[7]}, {1'b1, 4'h9});
    fixed_master_index[7] = 4'hB;
    repeat (2) @(negedge sys_clk);
    chk({s_connected[7], s_master[7]}, {1'b1, 4'hB});
    settle("defaults");
    go(2, 5, BURST_SINGLE, 1);
    note(2, 1);
    #1 chk(m_grant[2], 1'b0);
    @(posedge sys_clk);
    #1 chk(m_grant[2], 1'b1);
    settle("no_default");
    chk(s_connected[5], 1'b0);
    go(3, 6, BURST_SINGLE, 1);
    note(3, 1);
    settle("last_first");
    chk({s_connected[6], s_master[6]}, {1'b1, 4'h3});
    go(3, 6, BURST_SINGLE, 1);
    note(3, 1);
    #1 chk(m_grant[3], 1'b1);
    settle("last_again");
    go(1, 1, BURST_SINGLE, 1);
    go(4, 1, BURST_SINGLE, 1);
    go(8, 1, BURST_SINGLE, 1);
    note(1, 1);
    note(4, 1);
    note(8, 1);
    settle("round_robin");
    for (int m = 0; m < 11; m += 5) go(m, 2, BURST_SINGLE, 1);
    note(10, 1);
    note(5, 1);
    note(0, 1);
    settle("fixed_priority");
    go(0, 3, BURST_4_MIN, 4);
    note(0, 4);
    @(negedge sys_clk);
    go(1, 3, BURST_SINGLE, 1);
    note(1, 1);
    repeat (6) @(negedge sys_clk) stall[3] = ^rnd();
    stall[3] = 1'b0;
    settle("burst_hold");
    go(0, 4, BURST_INCR, 3);
    note(0, 1);
    @(negedge sys_clk);
    go(1, 4, BURST_SINGLE, 1);
    note(1, 1);
    note(0, 2);
    settle("undefined_burst");
    // Four-beat prediction breaks an undefined burst after its fourth beat.
    undefined_burst_break_select[2] = UB_FOUR;
    go(2, 10, BURST_INCR, 5);
    note(2, 4);
    @(negedge sys_clk);
    go(3, 10, BURST_SINGLE, 1);
    note(3, 1);
    note(2, 1);
    settle("four_beat_break");
    // A slot limit of three clocks breaks a long burst after the fourth beat.
    slot_cycle[8] = 8'h03;
    go(0, 8, BURST_16_MIN, 6);
    note(0, 4);
    @(negedge sys_clk);
    go(1, 8, BURST_SINGLE, 1);
    note(1, 1);
    note(0, 2);
    settle("slot_limit");
    sfw_wdata = rnd();
    sfw_wr_en[9] = 1'b1;
    @(negedge sys_clk);
    sfw_wr_en[9] = 1'b0;
    chk(special_function_word[9], sfw_wdata);
    chk(special_function_word[8], 32'h0000_0000);
    settle("spare_words");
    test_done();
  end
endmodule : test_bma_matrix
`default_nettype wire
